// ---- scg_pkg.sv ----
`default_nettype none
package scg_pkg;
   // ==========================================
   // board address map (offsets from base)
   localparam logic [15:0] PERIPH_BASE    = 16'h8000;
   localparam logic [8:0]  CONSOLE_LO     = 9'h000;
   localparam logic [8:0]  DMA_CTRL_LO    = 9'h080;
   localparam logic [8:0]  DMA_CHB_LO     = 9'h0C0;
   localparam logic [8:0]  DMA_CHA_LO     = 9'h0E0;
   localparam logic [8:0]  UNIV_LO        = 9'h100;
   localparam logic [8:0]  UNIV_CFG_OFS   = 9'h180;
   localparam logic [1:0]  BRK_ARM_A65    = 2'h3;
   localparam logic [1:0]  BRK_DISARM_A65 = 2'h2;
   localparam logic [8:0]  BRK_DISARM_OFS = 9'h040;
   // ==========================================
   // first-write bus configuration values
   localparam logic [7:0]  DMA_CFG_BYTE   = 8'hC6;
   localparam logic [15:0] UNIV_CFG_WORD  = 16'h0007;
   // ==========================================
   // host register map (APB byte addresses)
   localparam logic [7:0]  REG_CMD        = 8'h00;
   localparam logic [7:0]  REG_ADDR       = 8'h04;
   localparam logic [7:0]  REG_WDATA      = 8'h08;
   localparam logic [7:0]  REG_STATUS     = 8'h0C;
   localparam logic [7:0]  REG_RDATA      = 8'h10;
   localparam int          CMD_GO         = 0;
   localparam int          CMD_WRITE      = 1;
   localparam int          CMD_BYTE       = 2;
   localparam logic [31:0] REG_RESET      = 32'h0000_0000;
   // ==========================================
   // bus cycle timing
   localparam int          CLK_NS         = 100;
   localparam int          STROBE_NS      = 200;
   localparam int          STROBE_CYC     = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   // host sequencer states
   typedef enum logic [1:0] {
      SCG_IDLE   = 2'b00,
      SCG_ADDR   = 2'b01,
      SCG_STROBE = 2'b10,
      SCG_END    = 2'b11
   } scg_bus_e;
endpackage
`default_nettype wire

// ---- scg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface scg_if;
   // multiplexed host bus, driven by the host end
   logic        ale;
   logic        rd_n;
   logic        wr_n;
   logic        bhe_n;
   logic [15:0] ad_host;
   logic        ad_host_oe;
   logic [15:0] ad_ext;   // controller read data, from the bench
   logic [15:0] ad;
   // glue answers toward the host
   logic        nmi;
   logic        host_dma_req_zero;
   logic        host_dma_req_one;
   // resolved bus level
   assign ad = ad_host_oe ? ad_host : ad_ext;
   modport host (output ale, rd_n, wr_n, bhe_n, ad_host, ad_host_oe,
                 input ad, nmi, host_dma_req_zero, host_dma_req_one);
   modport glue (input ale, rd_n, wr_n, bhe_n, ad,
                 output nmi, host_dma_req_zero, host_dma_req_one);
endinterface
`default_nettype wire

// ---- scg_host.sv ----
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scg_host
   import scg_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // multiplexed bus
   scg_if.host              bus
);
   // ==========================================
   // registers
   logic [15:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        write;
   logic        byte_acc;
   logic        busy;
   logic [1:0]  boot;       // configuration writes still owed
   logic [7:0]  nmi_count;
   logic        nmi_q;
   logic        nmi_pend;   // nmi rise waiting for an idle bus
   scg_bus_e    state;
   logic [3:0]  cnt;
   // apb decode
   wire access   = psel & penable & ~pready;
   wire wr_cmd   = access & pwrite & (paddr == REG_CMD);
   wire mapped   = (paddr == REG_CMD) | (paddr == REG_ADDR) | (paddr == REG_WDATA)
                 | (paddr == REG_STATUS) | (paddr == REG_RDATA);
   wire sw_go    = wr_cmd & pwdata[CMD_GO] & ~busy;
   wire nmi_rise = bus.nmi & ~nmi_q;
   wire [31:0] rd_mux =
      (paddr == REG_ADDR)   ? {16'h0000, addr} :
      (paddr == REG_WDATA)  ? {16'h0000, wdata} :
      (paddr == REG_STATUS) ? {16'h0000, nmi_count, 4'h0, bus.host_dma_req_one,
                               bus.host_dma_req_zero, boot == 2'h0, busy} :
      (paddr == REG_RDATA)  ? {16'h0000, rdata} : REG_RESET;
   // apb answer one cycle after the access phase opens
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= REG_RESET;
      end else begin
         pready  <= access;
         pslverr <= access & ~mapped;
         prdata  <= (access & ~pwrite) ? rd_mux : REG_RESET;
      end
   end
   // ==========================================
   // command start: boot configuration, nmi handler, software
   wire start_boot = (state == SCG_IDLE) & (boot != 2'h0);
   // a rise seen while busy is held in nmi_pend, else the handler read is lost
   wire start_nmi  = (state == SCG_IDLE) & (boot == 2'h0) & (nmi_rise | nmi_pend);
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         addr      <= 16'h0000;
         wdata     <= 16'h0000;
         write     <= 1'b0;
         byte_acc  <= 1'b0;
         boot      <= 2'h3;
         nmi_q     <= 1'b0;
         nmi_count <= 8'h00;
         nmi_pend  <= 1'b0;
      end else begin
         nmi_q <= bus.nmi;
         nmi_pend <= ~start_nmi & (nmi_pend | nmi_rise);
         if (nmi_rise)
            nmi_count <= nmi_count + 8'h01;
         if (start_boot && boot[1]) begin
            addr     <= PERIPH_BASE + {7'h00, DMA_CTRL_LO};
            wdata    <= {8'h00, DMA_CFG_BYTE};
            write    <= 1'b1;
            byte_acc <= 1'b1;
            boot     <= 2'h1;
         end else if (start_boot) begin
            addr     <= PERIPH_BASE + {7'h00, UNIV_CFG_OFS};
            wdata    <= UNIV_CFG_WORD;
            write    <= 1'b1;
            byte_acc <= 1'b0;
            boot     <= 2'h0;
         end else if (start_nmi) begin      // disarm read
            addr     <= PERIPH_BASE + {7'h00, BRK_DISARM_OFS};
            write    <= 1'b0;
            byte_acc <= 1'b1;
         end else begin
            if (access && pwrite && paddr == REG_ADDR && !busy)
               addr <= pwdata[15:0];
            if (access && pwrite && paddr == REG_WDATA && !busy)
               wdata <= pwdata[15:0];
            if (sw_go && state == SCG_IDLE) begin
               write    <= pwdata[CMD_WRITE];
               byte_acc <= pwdata[CMD_BYTE];
            end
         end
      end
   end
   // ==========================================
   // bus cycle: address with ale, then strobe, then release
   wire go = (state == SCG_IDLE) & (start_boot | start_nmi | sw_go);
   // boot and nmi cycles load addr on the go edge, so the ale phase takes it here
   wire [15:0] boot_addr = PERIPH_BASE + {7'h00, boot[1] ? DMA_CTRL_LO : UNIV_CFG_OFS};
   wire [15:0] nmi_addr  = PERIPH_BASE + {7'h00, BRK_DISARM_OFS};
   wire [15:0] go_addr   = start_boot ? boot_addr : (start_nmi ? nmi_addr : addr);
   wire [15:0] lane_data = byte_acc ? {wdata[7:0], wdata[7:0]} : wdata;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state          <= SCG_IDLE;
         cnt            <= 4'h0;
         busy           <= 1'b0;
         rdata          <= 16'h0000;
         bus.ale        <= 1'b0;
         bus.rd_n       <= 1'b1;
         bus.wr_n       <= 1'b1;
         bus.bhe_n      <= 1'b1;
         bus.ad_host    <= 16'h0000;
         bus.ad_host_oe <= 1'b0;
      end else begin
         case (state)
            SCG_IDLE: if (go) begin
               state          <= SCG_ADDR;
               busy           <= 1'b1;
               bus.ale        <= 1'b1;
               bus.ad_host_oe <= 1'b1;
            end
            SCG_ADDR: begin
               state          <= SCG_STROBE;
               cnt            <= 4'(STROBE_CYC);
               bus.ale        <= 1'b0;
               bus.rd_n       <= write;
               bus.wr_n       <= ~write;
               bus.bhe_n      <= byte_acc & ~addr[0];
               bus.ad_host_oe <= write;
            end
            SCG_STROBE: begin
               cnt <= cnt - 4'h1;
               if (cnt == 4'h1) begin
                  state <= SCG_END;
                  if (!write)
                     rdata <= byte_acc ? (addr[0] ? {8'h00, bus.ad[15:8]}
                                                  : {8'h00, bus.ad[7:0]}) : bus.ad;
                  bus.rd_n <= 1'b1;
                  bus.wr_n <= 1'b1;
               end
            end
            SCG_END: begin
               state          <= SCG_IDLE;
               busy           <= 1'b0;
               bus.bhe_n      <= 1'b1;
               bus.ad_host_oe <= 1'b0;
            end
            default: state <= SCG_IDLE;
         endcase
         if (state == SCG_IDLE && go)
            bus.ad_host <= go_addr;
         else if (state == SCG_ADDR)
            bus.ad_host <= lane_data;
      end
   end
endmodule // scg_host
`default_nettype wire

// ---- scg_glue.sv ----
`timescale 1ns/1ps
`default_nettype none
module scg_glue
   import scg_pkg::*;
#(
   parameter logic [15:0] BASE = PERIPH_BASE
)(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // multiplexed host bus
   scg_if.glue       bus,
   // console line and dma requests from the controllers
   input  wire logic console_rxd,
   input  wire logic rx_dma_request_n,
   input  wire logic tx_dma_request_n,
   // jumper straps for dma routing
   input  wire logic dma_swap,
   input  wire logic dma_rx_en,
   input  wire logic dma_tx_en,
   // controller selects and address pins
   output var  logic console_sel,
   output var  logic dma_ctrl_sel,
   output var  logic univ_sel,
   output var  logic chan_sel,
   output var  logic serial_or_dma_select,
   output var  logic page_select_in,
   output var  logic data_ctrl_sel,
   output var  logic univ_wide,
   output var  logic univ_chan_a,
   output var  logic low_lane_only,
   output var  logic addr_strobe_in_n,
   // unused ack pins, weakly pulled up
   output var  logic rx_dma_ack_o,
   output var  logic rx_dma_ack_oe,
   output var  logic tx_dma_ack_o,
   output var  logic tx_dma_ack_oe,
   // state
   output var  logic break_armed,
   output var  logic dma_cfg_done,
   output var  logic univ_cfg_done
);
   // ==========================================
   // address latch on ale
   logic [15:0] lat_addr;
   logic        nmi_r;
   logic        req0_r;
   logic        req1_r;
   always_ff @(posedge core_clk) begin
      if (!reset_n)
         lat_addr <= 16'h0000;
      else if (bus.ale)
         lat_addr <= bus.ad;
   end
   // ==========================================
   // window decode on the latched address
   wire [8:0] ofs     = lat_addr[8:0];
   wire       in_base = (lat_addr[15:9] == BASE[15:9]);
   wire       strobe  = ~bus.rd_n | ~bus.wr_n;
   wire       rd_act  = ~bus.rd_n;
   wire       wr_act  = ~bus.wr_n;
   wire       hit_con = in_base & (ofs < DMA_CTRL_LO);
   // only even bytes reach the dma controller
   wire       hit_dma = in_base & (ofs >= DMA_CTRL_LO) & (ofs < UNIV_LO)
                      & ~lat_addr[0];
   wire       hit_uni = in_base & (ofs >= UNIV_LO);
   // one window at most, none outside the map
   wire       sel_con = strobe & hit_con;
   wire       sel_dma = strobe & hit_dma & ~hit_con;
   wire       sel_uni = strobe & hit_uni & ~hit_con & ~hit_dma;
   // ==========================================
   // break-detect arming on console reads
   wire [1:0] a65     = lat_addr[6:5];
   wire       arm     = rd_act & hit_con & (a65 == BRK_ARM_A65);
   wire       disarm  = rd_act & hit_con & (a65 == BRK_DISARM_A65);
   wire       next_nmi = break_armed & ~console_rxd;
   always_ff @(posedge core_clk) begin
      if (!reset_n)
         break_armed <= 1'b0;
      else if (arm)
         break_armed <= 1'b1;
      else if (disarm)
         break_armed <= 1'b0;
   end
   // ==========================================
   // first-write configuration tracking
   // a dma-window write with address bit six low, or a universal-window write with bit seven high, is taken as the bus configuration word
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         dma_cfg_done  <= 1'b0;
         univ_cfg_done <= 1'b0;
      end else begin
         if (wr_act && sel_dma && !lat_addr[6])
            dma_cfg_done <= 1'b1;
         if (wr_act && sel_uni && lat_addr[7])
            univ_cfg_done <= 1'b1;
      end
   end
   // ==========================================
   // dma request routing by straps, requests active low
   wire rx_req = ~rx_dma_request_n & dma_rx_en;
   wire tx_req = ~tx_dma_request_n & dma_tx_en;
   wire next_req0 = dma_swap ? tx_req : rx_req;
   wire next_req1 = dma_swap ? rx_req : tx_req;
   // ==========================================
   // registered pin drive; one cycle of skew keeps outputs glitch free
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         console_sel          <= 1'b0;
         dma_ctrl_sel         <= 1'b0;
         univ_sel             <= 1'b0;
         chan_sel             <= 1'b1;
         serial_or_dma_select <= 1'b0;
         page_select_in       <= 1'b0;
         univ_wide            <= 1'b0;
         univ_chan_a          <= 1'b0;
         low_lane_only        <= 1'b0;
         addr_strobe_in_n     <= 1'b1;
         nmi_r                <= 1'b0;
         req0_r               <= 1'b0;
         req1_r               <= 1'b0;
      end else begin
         console_sel          <= sel_con;
         dma_ctrl_sel         <= sel_dma;
         univ_sel             <= sel_uni;
         // pull-up level until configured, then address bit five
         chan_sel             <= dma_cfg_done ? lat_addr[5] : 1'b1;
         serial_or_dma_select <= lat_addr[6];
         page_select_in       <= lat_addr[7];
         univ_wide            <= hit_uni & ~lat_addr[6];
         univ_chan_a          <= hit_uni & lat_addr[7];
         low_lane_only        <= sel_dma;
         addr_strobe_in_n     <= ~bus.ale;
         nmi_r                <= next_nmi;
         req0_r               <= next_req0;
         req1_r               <= next_req1;
      end
   end
   // constant-level pins and pulled-up ack pins
   always_ff @(posedge core_clk) begin
      data_ctrl_sel <= 1'b0;
      rx_dma_ack_o  <= 1'b1;
      rx_dma_ack_oe <= 1'b0;
      tx_dma_ack_o  <= 1'b1;
      tx_dma_ack_oe <= 1'b0;
   end
   assign bus.nmi               = nmi_r;
   assign bus.host_dma_req_zero = req0_r;
   assign bus.host_dma_req_one  = req1_r;
endmodule // scg_glue
`default_nettype wire

// ---- scg_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module scg_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // host bus and answers
   input wire logic ale,
   input wire logic rd_n,
   input wire logic nmi,
   input wire logic host_dma_req_zero,
   input wire logic host_dma_req_one,
   // glue inputs
   input wire logic console_rxd,
   input wire logic rx_dma_request_n,
   input wire logic tx_dma_request_n,
   input wire logic dma_swap,
   input wire logic dma_rx_en,
   input wire logic dma_tx_en,
   // glue outputs
   input wire logic console_sel,
   input wire logic dma_ctrl_sel,
   input wire logic univ_sel,
   input wire logic data_ctrl_sel,
   input wire logic addr_strobe_in_n,
   input wire logic rx_dma_ack_o,
   input wire logic rx_dma_ack_oe,
   input wire logic tx_dma_ack_o,
   input wire logic tx_dma_ack_oe,
   input wire logic break_armed,
   input wire logic chan_sel,
   input wire logic dma_cfg_done
);
   // ==========================================
   // expected dma routing, strap dependent
   wire logic rx_live = dma_rx_en && !rx_dma_request_n;
   wire logic tx_live = dma_tx_en && !tx_dma_request_n;
   wire logic exp_req0 = dma_swap ? tx_live : rx_live;
   wire logic exp_req1 = dma_swap ? rx_live : tx_live;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // ==========================================
   // properties
   property p_nmi; 1'b1 |=> nmi == $past(break_armed && !console_rxd); endproperty
   a_nmi: assert property (p_nmi) else $error("nmi not armed and low rxd");
   property p_arm_cause;
      $rose(break_armed) |-> !rd_n || !$past(rd_n) || !$past(rd_n, 2) || !$past(rd_n, 3);
   endproperty
   a_arm_cause: assert property (p_arm_cause) else $error("break armed without read");
   property p_rst_clear; $rose(reset_n) |-> !break_armed; endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("break armed after reset");
   property p_strobe; $rose(ale) |=> !addr_strobe_in_n ##1 addr_strobe_in_n; endproperty
   a_strobe: assert property (p_strobe) else $error("address strobe wrong");
   property p_one_sel; $onehot0({console_sel, dma_ctrl_sel, univ_sel}); endproperty
   a_one_sel: assert property (p_one_sel) else $error("several selects");
   property p_ack_idle;
      rx_dma_ack_o && tx_dma_ack_o && !rx_dma_ack_oe && !tx_dma_ack_oe;
   endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("ack pins driven");
   property p_dc_low; !data_ctrl_sel; endproperty
   a_dc_low: assert property (p_dc_low) else $error("data select high");
   property p_req0; 1'b1 |=> host_dma_req_zero == $past(exp_req0); endproperty
   a_req0: assert property (p_req0) else $error("dma request zero wrong");
   property p_req1; 1'b1 |=> host_dma_req_one == $past(exp_req1); endproperty
   a_req1: assert property (p_req1) else $error("dma request one wrong");
   property p_chan_cfg; !dma_cfg_done |=> chan_sel; endproperty
   a_chan_cfg: assert property (p_chan_cfg) else $error("channel select low before config");
endmodule // scg_chk
`default_nettype wire

// ---- serial_ctrl_host_glue_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_host_glue_tb;
   import scg_pkg::*;
   logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, clr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic rxd, rx_n, tx_n, swap, rx_en, tx_en, c_sel, d_sel, u_sel, sod, pg, dc, wide, cha;
   logic ras, rao, raoe, tao, taoe, armed, d_done, u_done, chs, low;
   logic [2:0] seen;
   logic [5:0] cap;
   logic [8:0] dcap;
   logic [16:0] ucap;
   int err_total, n_tests;
   scg_if bus_if();
   scg_host i_scg_host (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(bus_if.host));
   scg_glue i_scg_glue (.core_clk(core_clk), .reset_n(reset_n), .bus(bus_if.glue),
      .console_rxd(rxd), .rx_dma_request_n(rx_n), .tx_dma_request_n(tx_n), .dma_swap(swap),
      .dma_rx_en(rx_en), .dma_tx_en(tx_en), .console_sel(c_sel), .dma_ctrl_sel(d_sel),
      .univ_sel(u_sel), .chan_sel(chs), .serial_or_dma_select(sod), .page_select_in(pg),
      .data_ctrl_sel(dc), .univ_wide(wide), .univ_chan_a(cha), .low_lane_only(low),
      .addr_strobe_in_n(ras), .rx_dma_ack_o(rao), .rx_dma_ack_oe(raoe), .tx_dma_ack_o(tao),
      .tx_dma_ack_oe(taoe), .break_armed(armed), .dma_cfg_done(d_done), .univ_cfg_done(u_done));
   scg_chk i_scg_chk (.core_clk(core_clk), .reset_n(reset_n), .ale(bus_if.ale),
      .rd_n(bus_if.rd_n), .nmi(bus_if.nmi), .host_dma_req_zero(bus_if.host_dma_req_zero),
      .host_dma_req_one(bus_if.host_dma_req_one), .console_rxd(rxd), .rx_dma_request_n(rx_n),
      .tx_dma_request_n(tx_n), .dma_swap(swap), .dma_rx_en(rx_en), .dma_tx_en(tx_en),
      .console_sel(c_sel), .dma_ctrl_sel(d_sel), .univ_sel(u_sel), .data_ctrl_sel(dc),
      .addr_strobe_in_n(ras), .rx_dma_ack_o(rao), .rx_dma_ack_oe(raoe), .tx_dma_ack_o(tao),
      .tx_dma_ack_oe(taoe), .break_armed(armed), .chan_sel(chs), .dma_cfg_done(d_done));
   // ==========================================
   // clock, and sticky select capture per bus cycle
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      seen <= clr ? 3'h0 : (seen | {c_sel, d_sel, u_sel});
      if (c_sel | d_sel | u_sel) cap <= {chs, low, sod, pg, wide, cha};
      // write data and byte enable as the dma and universal controllers see their strobe
      if (d_sel & !bus_if.wr_n) dcap <= {bus_if.bhe_n, bus_if.ad[7:0]};
      if (u_sel & !bus_if.wr_n) ucap <= {bus_if.bhe_n, bus_if.ad};
   end
   // ==========================================
   // shared tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) err_total++;
      rdat = pslverr ? 32'hDEAD_0000 : prdata;  // error flagged in high half
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // poll busy; bounded because an auto disarm read may be running
   task wait_idle;
      int n;
      n = 0;
      rdat = 32'h1;
      while (rdat[0] !== 1'b0 && n < 50) begin apb(1'b0, REG_STATUS, 32'h0); n++; end
      if (rdat[0] !== 1'b0) err_total++;
   endtask
   task bus(input logic w, input logic b, input logic [15:0] a);
      wait_idle();
      clr <= 1'b1;
      apb(1'b1, REG_ADDR, {16'h0, a});
      clr <= 1'b0;
      apb(1'b1, REG_CMD, {29'h0, b, w, 1'b1});
      wait_idle();
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task t_boot;
      int n;
      n = 0;
      rdat = 32'h0;
      while (rdat[1] !== 1'b1 && n < 100) begin apb(1'b0, REG_STATUS, 32'h0); n++; end
      if (rdat[1] !== 1'b1) err_total++;
      // boot done rises as the second write starts; let it finish
      wait_idle();
      chk({31'h0, d_done}, 32'h1);
      chk({23'h0, dcap}, 32'h1C6);
      chk({15'h0, ucap}, 32'h0007);
      chk({31'h0, u_done}, 32'h1);
      chk({28'h0, rao, raoe, tao, taoe}, 32'hA);
      apb(1'b0, 8'h20, 32'h0);
      chk(rdat, 32'hDEAD_0000);
      $display("boot test done");
   endtask
   task t_break;
      rxd <= 1'b1;
      bus(1'b0, 1'b1, 16'h8060);
      chk({31'h0, armed}, 32'h1);
      bus(1'b0, 1'b1, 16'h8040);
      chk({31'h0, armed}, 32'h0);
      rxd <= 1'b0;
      repeat (5) @(posedge core_clk);
      chk({31'h0, bus_if.nmi}, 32'h0);
      bus(1'b0, 1'b1, 16'h8060);
      repeat (20) @(posedge core_clk);
      wait_idle();
      chk({31'h0, armed}, 32'h0);
      chk({24'h0, rdat[15:8]}, 32'h1);
      rxd <= 1'b1;
      $display("break test done");
   endtask
   task t_decode;
      logic [15:0] da [9];
      logic [2:0] ds [9];
      da = '{16'h8000, 16'h8082, 16'h8083, 16'h80C0, 16'h80E0, 16'h8100, 16'h81C0, 16'h8200,
             16'h7FFE};
      ds = '{3'h4, 3'h2, 3'h0, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, 1'b1, da[i]);
         chk({29'h0, seen}, {29'h0, ds[i]});
         if (ds[i] != 3'h0) chk({26'h0, cap}, {26'h0, da[i][5], ds[i][1], da[i][6], da[i][7],
            ds[i][0] & !da[i][6], ds[i][0] & da[i][7]});
      end
      bus(1'b0, 1'b0, 16'h8100);
      apb(1'b0, REG_RDATA, 32'h0);
      chk(rdat, 32'hA55A);
      bus(1'b0, 1'b1, 16'h8082);
      apb(1'b0, REG_RDATA, 32'h0);
      chk(rdat, 32'h5A);
      $display("decode test done");
   endtask
   task t_dma;
      logic e0, e1;
      for (int i = 0; i < 32; i++) begin
         {swap, rx_en, tx_en, rx_n, tx_n} <= i[4:0];
         e0 = i[4] ? (i[2] & !i[0]) : (i[3] & !i[1]);
         e1 = i[4] ? (i[3] & !i[1]) : (i[2] & !i[0]);
         repeat (3) @(posedge core_clk);
         chk({30'h0, bus_if.host_dma_req_one, bus_if.host_dma_req_zero}, {30'h0, e1, e0});
      end
      $display("dma routing test done");
   endtask
   // ==========================================
   // main sequence and watchdog
   initial begin
      reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; rxd = 1'b1; rx_n = 1'b1; tx_n = 1'b1; swap = 1'b0; rx_en = 1'b1;
      tx_en = 1'b1; clr = 1'b0; err_total = 0; n_tests = 0; bus_if.ad_ext = 16'hA55A;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      t_boot();
      t_break();
      t_decode();
      t_dma();
      stop_test();
   end
   initial begin
      #3000000;
      err_total++;
      stop_test();
   end
endmodule // serial_ctrl_host_glue_tb
`default_nettype wire
